// ==== pkg/mcmd_pkg.sv ====
`default_nettype none
package mcmd_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Instruction field positions.
	localparam int SRC_HI         = 15;
	localparam int SRC_LO         = 13;
	localparam int PTRC_HI        = 12;
	localparam int PTRC_LO        = 11;
	localparam int DST_HI         = 10;
	localparam int DST_LO         = 8;
	localparam int FUNC_HI        = 7;
	localparam int FUNC_LO        = 4;
	localparam int LOW_HI         = 3;
	localparam int LOW_LO         = 0;
	localparam int IMM_HI         = 7;
	localparam int IMM_LO         = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Source codes.
	localparam logic [2:0] SRC_IMMEDIATE  = 3'h0;
	localparam logic [2:0] SRC_INPUT_BUS  = 3'h1;
	localparam logic [2:0] SRC_MEMORY     = 3'h2;
	localparam logic [2:0] SRC_BRANCH_REG = 3'h3;
	localparam logic [2:0] SRC_ALT_INPUT  = 3'h5;

	// Destination codes.
	localparam logic [2:0] DST_NONE       = 3'h0;
	localparam logic [2:0] DST_ALT_OUTPUT = 3'h2;
	localparam logic [2:0] DST_BR_SHIFT   = 3'h3;
	localparam logic [2:0] DST_OUTPUT     = 3'h4;
	localparam logic [2:0] DST_MEMORY     = 3'h5;
	localparam logic [2:0] DST_SCRATCH    = 3'h6;
	localparam logic [2:0] DST_BR_SCRATCH = 3'h7;

	// Pointer control codes.
	localparam logic [1:0] PTR_HOLD       = 2'h0;
	localparam logic [1:0] PTR_LOAD_LOW   = 2'h1;
	localparam logic [1:0] PTR_LOAD_PAGE  = 2'h2;
	localparam logic [1:0] PTR_INCREMENT  = 2'h3;

	////////////////////////////////////////////////////////////////////////////////
	// ALU function codes.
	localparam logic [3:0] ALU_ADD        = 4'h0;
	localparam logic [3:0] ALU_ADD_CARRY  = 4'h1;
	localparam logic [3:0] ALU_SUB_BORROW = 4'h2;
	localparam logic [3:0] ALU_INC_A      = 4'h3;
	localparam logic [3:0] ALU_A_CARRY    = 4'h4;
	localparam logic [3:0] ALU_DOUBLE_A   = 4'h5;
	localparam logic [3:0] ALU_DOUBLE_AC  = 4'h6;
	localparam logic [3:0] ALU_DEC_A      = 4'h7;
	localparam logic [3:0] ALU_PASS_A     = 4'h8;
	localparam logic [3:0] ALU_PASS_B     = 4'h9;
	localparam logic [3:0] ALU_A_OR_NB    = 4'ha;
	localparam logic [3:0] ALU_A_AND_B    = 4'hb;
	localparam logic [3:0] ALU_A_OR_B     = 4'hc;
	localparam logic [3:0] ALU_A_XOR_B    = 4'hd;
	localparam logic [3:0] ALU_SUB        = 4'he;
	localparam logic [3:0] ALU_SUB_ONES   = 4'hf;

	localparam logic [7:0] ALL_ONES       = 8'hff;
	localparam logic [9:0] PTR_ONE        = 10'h001;
	localparam logic [3:0] SCRATCH_ZERO   = 4'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses.
	localparam logic [7:0] OFS_CONTROL    = 8'h00;
	localparam logic [7:0] OFS_STATUS     = 8'h04;
	localparam logic [7:0] OFS_BRANCH     = 8'h08;
	localparam logic [7:0] OFS_POINTER    = 8'h0c;
	localparam logic [7:0] OFS_SP_INDEX   = 8'h10;
	localparam logic [7:0] OFS_SP_DATA    = 8'h14;

	// Status and control field positions.
	localparam int STAT_CARRY     = 0;
	localparam int STAT_ZERO      = 1;
	localparam int STAT_PTR_LO    = 16;
	localparam int STAT_PTR_HI    = 25;
	localparam int CTRL_RUN       = 0;

	// Reset values.
	localparam logic       RST_RUN        = 1'b1;
	localparam logic       RST_CARRY      = 1'b0;
	localparam logic       RST_ZERO       = 1'b0;
	localparam logic [9:0] RST_PTR        = 10'h000;
	localparam logic [7:0] RST_BRANCH     = 8'h00;

endpackage
`default_nettype wire

// ==== logic/mcmd_alu.sv ====
`timescale 1ns/100ps
`default_nettype none
module mcmd_alu
	import mcmd_pkg::*;
(
	input  wire logic [3:0] func,
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic       carry_in,
	output logic      [7:0] result,
	output logic            carry_out,
	output logic            carry_used
);

	logic [7:0] addend;
	logic       cin;
	logic [8:0] sum;
	logic [7:0] logic_res;

	// Every arithmetic code is one 9-bit add; subtracts add the complement so the
	// carry out reads as "no borrow".
	always_comb begin
		addend     = 8'h00;
		cin        = 1'b0;
		carry_used = 1'b1;
		logic_res  = a;
		case (func)
			ALU_ADD:        addend = b; // RULE_16
			ALU_ADD_CARRY: begin
				addend = b;
				cin    = carry_in;
			end
			ALU_SUB_BORROW: begin
				addend = ~b;
				cin    = carry_in; // RULE_18
			end
			ALU_INC_A:      cin = 1'b1;
			ALU_A_CARRY:    cin = carry_in;
			ALU_DOUBLE_A:   addend = a;
			ALU_DOUBLE_AC: begin
				addend = a;
				cin    = carry_in;
			end
			ALU_DEC_A:      addend = ALL_ONES;
			ALU_SUB: begin
				addend = ~b;
				cin    = 1'b1;
			end
			ALU_SUB_ONES:   addend = ~b;
			ALU_PASS_A: begin // RULE_17
				carry_used = 1'b0;
				logic_res  = a;
			end
			ALU_PASS_B: begin
				carry_used = 1'b0;
				logic_res  = b;
			end
			ALU_A_OR_NB: begin
				carry_used = 1'b0;
				logic_res  = a | ~b;
			end
			ALU_A_AND_B: begin
				carry_used = 1'b0;
				logic_res  = a & b;
			end
			ALU_A_OR_B: begin
				carry_used = 1'b0;
				logic_res  = a | b;
			end
			ALU_A_XOR_B: begin
				carry_used = 1'b0;
				logic_res  = a ^ b;
			end
			default:        carry_used = 1'b0;
		endcase
		sum       = {1'b0, a} + {1'b0, addend} + {8'h00, cin};
		carry_out = sum[8];
		result    = carry_used ? sum[7:0] : logic_res;
	end

endmodule // mcmd_alu
`default_nettype wire

// ==== logic/mcmd_datapath.sv ====
//
// Function
// (RULE_01) Pointer field selects hold, low, page, increment.
// (RULE_02) Pointer codes 00,01,10,11 in that order.
// (RULE_03) Low load writes result into pointer 7:0.
// (RULE_04) Page load writes result 1:0 to 9:8.
// (RULE_05) Increment after transfer, wraps at top.
// (RULE_06) ALU B from source, A from scratch.
// (RULE_07) Immediate, input bus, alternate input bus sources.
// (RULE_08) Memory, branch sources use function and A index.
// (RULE_09) Output destination forces scratch zero on A.
// (RULE_10) Output destinations addressed by low four bits.
// (RULE_11) Memory at pointer, scratch at low bits.
// (RULE_12) Code 111 writes branch and scratch.
// (RULE_13) Branch shift puts result bit zero in seven.
// (RULE_14) Branch shifts right, rotating when also source.
// (RULE_15) No destination still updates carry and zero.
// (RULE_16) Arithmetic codes 0000 to 0111 in order.
// (RULE_17) Logical codes 1000 to 1101 in order.
// (RULE_18) Borrow subtract uses complement of carry.
// (RULE_19) Adds set carry on carry out.
// (RULE_20) Subtracts clear carry on borrow.
// (RULE_21) Logical functions leave carry alone.
// (RULE_22) Zero flag set when result is all ones.
// (RULE_23) Two's subtract carry means A at least B.
// (RULE_24) Ones subtract: carry A above B, equal all-ones.
// (RULE_25) Sixteen-bit word, source 15:13, destination 10:8.
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module mcmd_datapath
	import mcmd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [15:0] instr,
	input  wire logic        instr_valid,
	output logic             instr_ready,
	output logic      [3:0]  in_addr,
	output logic             in_alt,
	input  wire logic [7:0]  in_data,
	output logic      [9:0]  mem_raddr,
	input  wire logic [7:0]  mem_rdata,
	output logic             mem_we,
	output logic      [9:0]  mem_waddr,
	output logic      [7:0]  mem_wdata,
	output logic             out_we,
	output logic             out_alt,
	output logic      [3:0]  out_addr,
	output logic      [7:0]  out_data,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr
);

	typedef struct packed {
		logic             run;
		logic             carry;
		logic             zero;
		logic [9:0]       ptr;
		logic [7:0]       br;
		logic [3:0]       sp_sel;
		logic [15:0][7:0] scratch;
		logic             out_we;
		logic             out_alt;
		logic [3:0]       out_addr;
		logic [7:0]       out_data;
		logic             mem_we;
		logic [9:0]       mem_waddr;
		logic [7:0]       mem_wdata;
		logic [31:0]      prdata;
	} mcmd_state_t;

	mcmd_state_t st;
	mcmd_state_t next_st;

	////////////////////////////////////////////////////////////////////////////////
	// Decode helpers.

	function automatic logic is_output_dest(input logic [2:0] dst);
		is_output_dest = (dst == DST_OUTPUT) || (dst == DST_ALT_OUTPUT); // RULE_10
	endfunction

	function automatic logic is_mapped(input logic [31:0] addr);
		is_mapped = (addr[31:8] == 24'h000000) &&
			((addr[7:0] == OFS_CONTROL) || (addr[7:0] == OFS_STATUS) ||
			(addr[7:0] == OFS_BRANCH) || (addr[7:0] == OFS_POINTER) ||
			(addr[7:0] == OFS_SP_INDEX) || (addr[7:0] == OFS_SP_DATA));
	endfunction

	// Exact word match, so an alias above the map never hits.
	function automatic logic is_reg(input logic [31:0] addr, input logic [7:0] ofs);
		is_reg = (addr == {24'h000000, ofs});
	endfunction

	function automatic logic writes_scratch(input logic [2:0] code);
		writes_scratch = (code == DST_SCRATCH) || (code == DST_BR_SCRATCH); // RULE_11 RULE_12
	endfunction

	function automatic logic takes_func(input logic [2:0] code);
		takes_func = (code == SRC_MEMORY) || (code == SRC_BRANCH_REG); // RULE_08
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Instruction fields.

	logic [2:0] src;
	logic [2:0] dst;
	logic [1:0] ptr_ctl;
	logic [3:0] func;
	logic [3:0] low_idx;
	logic [3:0] a_idx;
	logic [7:0] src_bus;
	logic [7:0] alu_a;
	logic [7:0] alu_res;
	logic       alu_cout;
	logic       alu_cused;
	logic       exec;
	logic       apb_setup;
	logic       apb_write;
	logic       apb_access;

	assign src     = instr[SRC_HI:SRC_LO]; // RULE_25
	assign dst     = instr[DST_HI:DST_LO]; // RULE_25
	assign ptr_ctl = instr[PTRC_HI:PTRC_LO]; // RULE_01
	assign low_idx = instr[LOW_HI:LOW_LO];
	assign exec    = instr_valid && st.run;

	// Input-bus registers live outside; the address is steered straight from the word.
	assign in_addr = instr[FUNC_HI:FUNC_LO]; // RULE_07
	assign in_alt  = (src == SRC_ALT_INPUT); // RULE_07

	// The read port always faces the current pointer, so a read sees it before any increment.
	assign mem_raddr = st.ptr; // RULE_08

	////////////////////////////////////////////////////////////////////////////////
	// Source bus and ALU operand selection.

	always_comb begin
		src_bus = 8'h00;
		func    = ALU_PASS_B;
		case (src)
			SRC_IMMEDIATE:  src_bus = instr[IMM_HI:IMM_LO]; // RULE_07
			SRC_INPUT_BUS:  src_bus = in_data; // RULE_07
			SRC_ALT_INPUT:  src_bus = in_data; // RULE_07
			SRC_MEMORY: begin
				src_bus = mem_rdata; // RULE_08
				func    = instr[FUNC_HI:FUNC_LO]; // RULE_08
			end
			SRC_BRANCH_REG: begin
				src_bus = st.br; // RULE_08
				func    = instr[FUNC_HI:FUNC_LO]; // RULE_08
			end
			default:        src_bus = 8'h00;
		endcase
	end

	// The low bits double as the output address, so the A side falls back to location zero.
	assign a_idx = (takes_func(src) && is_output_dest(dst)) ? SCRATCH_ZERO : low_idx; // RULE_09
	assign alu_a = st.scratch[a_idx]; // RULE_06

	mcmd_alu u_alu (
		.func       (func),
		.a          (alu_a),
		.b          (src_bus), // RULE_06
		.carry_in   (st.carry), // RULE_18
		.result     (alu_res),
		.carry_out  (alu_cout),
		.carry_used (alu_cused)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Scratch pad write steering. Each location decodes its own enable, so a
	// wrong index can only ever disturb the one location that it names.

	logic [15:0]      sp_hw_we;
	logic [15:0]      sp_sw_we;
	logic [15:0][7:0] next_scratch;

	for (genvar gi = 0; gi < 16; gi++) begin : g_sp
		assign sp_hw_we[gi]     = exec && writes_scratch(dst) && (low_idx == 4'(gi)); // RULE_11 RULE_12
		assign sp_sw_we[gi]     = apb_write && pstrb[0] && is_reg(paddr, OFS_SP_DATA) &&
			(st.sp_sel == 4'(gi));
		// The instruction wins when software writes the same location in the same cycle.
		assign next_scratch[gi] = sp_hw_we[gi] ? alu_res : (sp_sw_we[gi] ? pwdata[7:0] : st.scratch[gi]);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Condition flags, held unless an instruction executes or software writes the status register.

	logic next_carry;
	logic next_zero;

	// Zero follows the ALU on every move, so a move with no destination still compares.
	assign next_zero  = (alu_res == ALL_ONES); // RULE_15 RULE_22 RULE_24
	// Logical and pass functions report no carry use and keep the old flag.
	assign next_carry = alu_cused ? alu_cout : st.carry; // RULE_19 RULE_20 RULE_21 RULE_23 RULE_24

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave: zero wait states, read data captured in the setup cycle.

	assign apb_setup   = psel && !penable;
	assign apb_access  = psel && penable;
	assign apb_write   = apb_access && pwrite;
	assign pready      = 1'b1;
	assign pslverr     = apb_access && !is_mapped(paddr);
	assign prdata      = st.prdata;
	assign instr_ready = st.run;

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		next_st           = st;
		next_st.out_we    = 1'b0;
		next_st.mem_we    = 1'b0;
		// The scratch pad comes whole from its steering logic.
		next_st.scratch   = next_scratch; // RULE_11 RULE_12

		// Software writes first, so an instruction in the same cycle overrides them.
		if (apb_write && is_mapped(paddr) && pstrb[0]) begin
			case (paddr[7:0])
				OFS_CONTROL:  next_st.run = pwdata[CTRL_RUN];
				OFS_STATUS: begin
					next_st.carry = pwdata[STAT_CARRY];
					next_st.zero  = pwdata[STAT_ZERO];
				end
				OFS_BRANCH:   next_st.br = pwdata[7:0];
				OFS_POINTER:  next_st.ptr[7:0] = pwdata[7:0];
				OFS_SP_INDEX: next_st.sp_sel = pwdata[3:0];
				default:      next_st.run = st.run;
			endcase
		end
		if (apb_write && is_reg(paddr, OFS_POINTER) && pstrb[1]) begin
			next_st.ptr[9:8] = pwdata[9:8];
		end

		if (apb_setup) begin
			next_st.prdata = 32'h00000000;
			case (paddr[7:0])
				OFS_CONTROL:  next_st.prdata[CTRL_RUN] = st.run;
				OFS_STATUS: begin
					next_st.prdata[STAT_CARRY]             = st.carry;
					next_st.prdata[STAT_ZERO]              = st.zero;
					next_st.prdata[STAT_PTR_HI:STAT_PTR_LO] = st.ptr;
				end
				OFS_BRANCH:   next_st.prdata[7:0] = st.br;
				OFS_POINTER:  next_st.prdata[9:0] = st.ptr;
				OFS_SP_INDEX: next_st.prdata[3:0] = st.sp_sel;
				OFS_SP_DATA:  next_st.prdata[7:0] = st.scratch[st.sp_sel];
				default:      next_st.prdata = 32'h00000000;
			endcase
			if (!is_mapped(paddr)) begin
				next_st.prdata = 32'h00000000;
			end
		end

		if (exec) begin
			// Flags move on every instruction, whatever the destination.
			next_st.zero  = next_zero; // RULE_22 RULE_15 RULE_24
			next_st.carry = next_carry; // RULE_19 RULE_20 RULE_21 RULE_23 RULE_24

			case (dst)
				DST_NONE:       next_st.br = next_st.br; // RULE_15
				DST_ALT_OUTPUT: begin
					next_st.out_we   = 1'b1; // RULE_10
					next_st.out_alt  = 1'b1;
					next_st.out_addr = low_idx;
					next_st.out_data = alu_res;
				end
				DST_OUTPUT: begin
					next_st.out_we   = 1'b1; // RULE_10
					next_st.out_alt  = 1'b0;
					next_st.out_addr = low_idx;
					next_st.out_data = alu_res;
				end
				DST_BR_SHIFT:   next_st.br = {alu_res[0], st.br[7:1]}; // RULE_13 RULE_14
				DST_MEMORY: begin
					next_st.mem_we    = 1'b1; // RULE_11
					next_st.mem_waddr = st.ptr;
					next_st.mem_wdata = alu_res;
				end
				DST_SCRATCH:    next_st.br = next_st.br; // RULE_11
				DST_BR_SCRATCH: begin
					next_st.br               = alu_res; // RULE_12
				end
				default:        next_st.br = next_st.br;
			endcase

			// The pointer moves after the transfer has used its old value.
			case (ptr_ctl)
				PTR_HOLD:      next_st.ptr = next_st.ptr; // RULE_01 RULE_02
				PTR_LOAD_LOW:  next_st.ptr[7:0] = alu_res; // RULE_02 RULE_03
				PTR_LOAD_PAGE: next_st.ptr[9:8] = alu_res[1:0]; // RULE_02 RULE_04
				PTR_INCREMENT: next_st.ptr = st.ptr + PTR_ONE; // RULE_02 RULE_05
				default:       next_st.ptr = next_st.ptr;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register. The scratch pad is cleared too, so a read before any write is defined.

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st.run       <= RST_RUN;
			st.carry     <= RST_CARRY;
			st.zero      <= RST_ZERO;
			st.ptr       <= RST_PTR;
			st.br        <= RST_BRANCH;
			st.sp_sel    <= 4'h0;
			st.scratch   <= '0;
			st.out_we    <= 1'b0;
			st.out_alt   <= 1'b0;
			st.out_addr  <= 4'h0;
			st.out_data  <= 8'h00;
			st.mem_we    <= 1'b0;
			st.mem_waddr <= 10'h000;
			st.mem_wdata <= 8'h00;
			st.prdata    <= 32'h00000000;
		end else begin
			st <= next_st;
		end
	end

	assign out_we    = st.out_we;
	assign out_alt   = st.out_alt;
	assign out_addr  = st.out_addr;
	assign out_data  = st.out_data;
	assign mem_we    = st.mem_we;
	assign mem_waddr = st.mem_waddr;
	assign mem_wdata = st.mem_wdata;

endmodule // mcmd_datapath
`default_nettype wire

// ==== bench/mcmd_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module mcmd_props
	import mcmd_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [15:0] instr,
	input wire logic        instr_valid,
	input wire logic        instr_ready,
	input wire logic [3:0]  in_addr,
	input wire logic        in_alt,
	input wire logic [9:0]  mem_raddr,
	input wire logic [7:0]  mem_rdata,
	input wire logic        mem_we,
	input wire logic [9:0]  mem_waddr,
	input wire logic        out_we,
	input wire logic        out_alt,
	input wire logic [3:0]  out_addr,
	input wire logic [7:0]  out_data,
	input wire logic        psel
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Register traffic may legally move the pointer, so cycles with a bus transfer are left out.
	logic       go;
	logic [2:0] src;
	logic [2:0] dst;
	logic [1:0] pc;
	logic [7:0] immediate_source;
	logic [1:0] pgin;
	logic [3:0] lowi;
	logic [1:0] pg;
	logic [7:0] lo;
	logic       altd;
	assign go   = instr_valid && instr_ready && !psel;
	assign src  = instr[15:13];
	assign pc   = instr[12:11];
	assign dst  = instr[10:8];
	assign immediate_source  = instr[7:0];
	assign pgin = instr[1:0];
	assign lowi = instr[3:0];
	assign pg   = mem_raddr[9:8];
	assign lo   = mem_raddr[7:0];
	assign altd = dst == DST_ALT_OUTPUT;
	////////////////////////////////////////
	a_ptr_hold: assert property (go && pc == PTR_HOLD |=> $stable(mem_raddr))
		else $error("pointer moved on hold");
	a_ptr_inc: assert property (go && pc == PTR_INCREMENT |=> mem_raddr == $past(mem_raddr) + PTR_ONE)
		else $error("pointer increment wrong");
	a_ptr_low: assert property (go && pc == PTR_LOAD_LOW && src == SRC_IMMEDIATE |=> lo == $past(immediate_source) && $stable(pg))
		else $error("pointer low load wrong");
	a_ptr_page: assert property (go && pc == PTR_LOAD_PAGE && src == SRC_IMMEDIATE |=> pg == $past(pgin) && $stable(lo))
		else $error("pointer page load wrong");
	a_mem_write: assert property (go && dst == DST_MEMORY |=> mem_we && mem_waddr == $past(mem_raddr))
		else $error("memory write missing");
	a_out_write: assert property (go && (dst == DST_OUTPUT || altd) |=> out_we && out_addr == $past(lowi) && out_alt == $past(altd))
		else $error("output write wrong");
	a_out_imm: assert property (go && src == SRC_IMMEDIATE && dst == DST_OUTPUT |=> out_data == $past(immediate_source))
		else $error("immediate operand wrong");
	a_no_dest: assert property (go && dst == DST_NONE |=> !out_we && !mem_we)
		else $error("write without destination");
	a_in_select: assert property (instr_valid |-> in_addr == instr[7:4] && in_alt == (src == SRC_ALT_INPUT))
		else $error("input select wrong");
	a_mem_pass: assert property (go && src == SRC_MEMORY && dst == DST_OUTPUT && instr[7:4] == ALU_PASS_B |=> out_data == $past(mem_rdata))
		else $error("memory operand wrong");
	c_wrap: cover property (go && pc == PTR_INCREMENT && mem_raddr == 10'h3ff);
	c_shift: cover property (go && dst == DST_BR_SHIFT);
	c_mem_out: cover property (go && src == SRC_MEMORY && dst == DST_OUTPUT);
endmodule // mcmd_props
bind mcmd_datapath mcmd_props u_props (.*);
`default_nettype wire

// ==== bench/mcmd_store.sv ====
`timescale 1ns/100ps
`default_nettype none
module mcmd_store (
	input wire logic       clk,
	input wire logic [3:0] in_addr,
	input wire logic       in_alt,
	output logic     [7:0] in_data,
	input wire logic [9:0] mem_raddr,
	output logic     [7:0] mem_rdata,
	input wire logic       mem_we,
	input wire logic [9:0] mem_waddr,
	input wire logic [7:0] mem_wdata
);
	logic [7:0] mem [1024];
	initial foreach (mem[i]) mem[i] = 8'h00;
	// Input registers read as their own address, so a wrong select shows as a wrong value.
	assign in_data   = {in_alt, 3'h2, in_addr};
	assign mem_rdata = mem[mem_raddr];
	always @(posedge clk) if (mem_we) mem[mem_waddr] <= mem_wdata;
endmodule // mcmd_store
`default_nettype wire

// ==== bench/mcmd_datapath_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module mcmd_datapath_tb;
	import mcmd_pkg::*;
	logic        clk = 0;
	logic        rst = 1;
	logic [15:0] instr = '0;
	logic        instr_valid = 0;
	logic        psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = '0, pwdata = '0, rd;
	logic [3:0]  pstrb = 4'hf;
	logic        instr_ready, in_alt, mem_we, out_we, out_alt, pready, pslverr;
	logic [3:0]  in_addr, out_addr;
	logic [7:0]  in_data, mem_rdata, mem_wdata, out_data, r;
	logic [9:0]  mem_raddr, mem_waddr;
	logic [31:0] prdata;
	logic [8:0]  e;
	logic        c, err;
	int          failures = 0, n_tests = 0, cyc = 0;
	mcmd_datapath dut (.*);
	mcmd_store store (.*);
	always #12.5 clk = ~clk;
	////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			report_and_stop();
		end
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge clk) penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] x);
		apb(0, a, 0);
		`CHK(nm, x, rd)
	endtask
	// Outputs are sampled 1 ns after the edge that ends the instruction, once its updates have landed.
	task automatic exec(input logic [2:0] s, input logic [1:0] p, input logic [2:0] d, input logic [7:0] lo);
		@(posedge clk);
		instr <= {s, p, d, lo};
		instr_valid <= 1;
		@(posedge clk) instr_valid <= 0;
		#1;
	endtask
	function automatic logic [8:0] alu_ref(logic [3:0] f, logic [7:0] a, logic [7:0] b, logic ci);
		logic [8:0] x;
		logic [7:0] nb;
		x = {1'b0, a};
		nb = ~b;
		case (f)
			4'h0: return x + b;
			4'h1: return x + b + ci;
			4'h2: return x + nb + ci;
			4'h3: return x + 9'h001;
			4'h4: return x + ci;
			4'h5: return x + a;
			4'h6: return x + a + ci;
			4'h7: return x + 8'hff;
			4'h8: return {ci, a};
			4'h9: return {ci, b};
			4'ha: return {ci, a | nb};
			4'hb: return {ci, a & b};
			4'hc: return {ci, a | b};
			4'hd: return {ci, a ^ b};
			4'he: return x + nb + 1;
			default: return x + nb;
		endcase
	endfunction
	////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk);
		rst <= 0;
		rdchk("run", OFS_CONTROL, 1);
		`CHK("slverr", 1'b0, err)
		apb(0, 8'h40, 0);
		`CHK("unmapped", 1'b1, err)
		`CHK("unmapped_rd", 32'h0, rd)
		wr(OFS_SP_INDEX, 2);
		for (int k = 0; k < 2; k++) for (int f = 0; f < 16; f++) begin
			c = (k == 0);
			wr(OFS_SP_DATA, k ? 8'h30 : 8'h5a);
			wr(OFS_BRANCH, k ? 8'hc5 : 8'h5a);
			wr(OFS_STATUS, {31'h0, c});
			exec(SRC_BRANCH_REG, PTR_HOLD, DST_SCRATCH, {f[3:0], 4'h2});
			e = alu_ref(f[3:0], k ? 8'h30 : 8'h5a, k ? 8'hc5 : 8'h5a, c);
			rdchk("alu", OFS_SP_DATA, {24'h0, e[7:0]});
			rdchk("flags", OFS_STATUS, {30'h0, e[7:0] == ALL_ONES, e[8]});
		end
		wr(OFS_POINTER, 10'h3ff);
		exec(SRC_IMMEDIATE, PTR_INCREMENT, DST_NONE, 8'h00);
		`CHK("wrap", 10'h000, mem_raddr)
		exec(SRC_IMMEDIATE, PTR_LOAD_LOW, DST_NONE, 8'ha5);
		`CHK("low", 10'h0a5, mem_raddr)
		exec(SRC_IMMEDIATE, PTR_LOAD_PAGE, DST_NONE, 8'hfe);
		`CHK("page", 10'h2a5, mem_raddr)
		exec(SRC_IMMEDIATE, PTR_HOLD, DST_NONE, 8'hff);
		rdchk("no_destination", OFS_STATUS, {6'h0, 10'h2a5, 14'h0, 1'b1, e[8]});
		exec(SRC_IMMEDIATE, PTR_INCREMENT, DST_MEMORY, 8'h3c);
		`CHK("mwe", 1'b1, mem_we)
		`CHK("maddr", 10'h2a5, mem_waddr)
		`CHK("mwdata", 8'h3c, mem_wdata)
		`CHK("inc", 10'h2a6, mem_raddr)
		wr(OFS_POINTER, 10'h2a5);
		exec(SRC_MEMORY, PTR_HOLD, DST_OUTPUT, {ALU_PASS_B, 4'h5});
		`CHK("mem", 8'h3c, out_data)
		`CHK("oaddr", 4'h5, out_addr)
		`CHK("owe", 1'b1, out_we)
		wr(OFS_SP_INDEX, 0);
		wr(OFS_SP_DATA, 8'h11);
		exec(SRC_MEMORY, PTR_HOLD, DST_ALT_OUTPUT, {ALU_PASS_A, 4'h5});
		`CHK("sp0", 8'h11, out_data)
		`CHK("alt", 1'b1, out_alt)
		for (int a = 0; a < 2; a++) begin
			exec(a ? SRC_ALT_INPUT : SRC_INPUT_BUS, PTR_HOLD, DST_OUTPUT, 8'h30);
			`CHK("alt_input_bus_regs", {a[0], 7'h23}, out_data)
		end
		wr(OFS_BRANCH, 8'h81);
		exec(SRC_IMMEDIATE, PTR_HOLD, DST_BR_SHIFT, 8'h01);
		rdchk("shift", OFS_BRANCH, 8'hc0);
		exec(SRC_BRANCH_REG, PTR_HOLD, DST_BR_SHIFT, {ALU_PASS_B, 4'h0});
		rdchk("rotate", OFS_BRANCH, 8'h60);
		exec(SRC_IMMEDIATE, PTR_HOLD, DST_BR_SCRATCH, 8'h77);
		rdchk("brsp", OFS_BRANCH, 8'h77);
		wr(OFS_SP_INDEX, 7);
		rdchk("branch_and_scratch_dest", OFS_SP_DATA, 8'h77);
		report_and_stop();
	end
endmodule // mcmd_datapath_tb
`default_nettype wire
